// ### rtl/dip_top.sv
// mode selection, byte loading and string check for id string programming
`timescale 1ns/1ps
module dip_top
	import dip_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// modem control pins to and from the host
	input  wire logic       dtr_pin,
	input  wire logic       rts_pin,
	output logic            cts_pin,
	// received bytes from the uart receiver
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	// discovery read port
	input  wire logic [4:0] disc_addr,
	output logic      [7:0] disc_data,
	// status
	output logic            prog_mode,
	output logic            init_done,
	output logic            link_allow
);
	//------------------------------------------------------------------
	// reset and pin synchronisers
	//------------------------------------------------------------------
	logic       rst_s1_reg;
	logic       rst_s2_reg;
	logic       dtr_s1_reg;
	logic       dtr_s2_reg;
	logic       rts_s1_reg;
	logic       rts_s2_reg;
	logic       rst_n;

	// async assert, synchronous release
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// modem pins come from the host's domain
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dtr_s1_reg <= 1'b0;
			dtr_s2_reg <= 1'b0;
			rts_s1_reg <= 1'b1;
			rts_s2_reg <= 1'b1;
		end else begin
			dtr_s1_reg <= dtr_pin;
			dtr_s2_reg <= dtr_s1_reg;
			rts_s1_reg <= rts_pin;
			rts_s2_reg <= rts_s1_reg;
		end
	end

	//------------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------------
	dip_state_e state_reg;
	logic [7:0] init_cnt_reg;
	logic [4:0] len_reg;
	logic [4:0] idx_reg;
	logic       sel_prog_reg;
	logic       bad_reg;
	logic       mem_wr;
	logic [4:0] mem_waddr;
	logic [4:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic [7:0] len_clip;
	logic       chk_pend_reg;
	logic [4:0] len_mem_reg;
	// length that bounds the character check on this boot
	logic [4:0] len_use;

	// over-long length is clipped so storage never exceeds the string limit
	assign len_clip = (rx_data > 8'(DIP_MAX_LEN)) ? 8'(DIP_MAX_LEN) : rx_data;

	// mode latch: sampled continuously while initializing, frozen afterwards
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_prog_reg <= 1'b0;
		end else if (state_reg == DIP_ST_INIT) begin
			sel_prog_reg <= dtr_s2_reg && !rts_s2_reg;
		end
	end

	// initialization timer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_reg <= 8'h00;
		end else if (state_reg == DIP_ST_INIT) begin
			init_cnt_reg <= init_cnt_reg + 8'h01;
		end
	end

	// main state machine
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DIP_ST_INIT;
			len_reg   <= 5'h00;
			idx_reg   <= 5'h00;
		end else begin
			case (state_reg)
				DIP_ST_INIT: begin
					if (init_cnt_reg == DIP_INIT_LAST) begin
						state_reg <= sel_prog_reg ? DIP_ST_LEN : DIP_ST_CHECK;
						idx_reg   <= 5'h00;
					end
				end
				DIP_ST_LEN: begin
					if (rx_valid) begin
						len_reg   <= len_clip[4:0];
						idx_reg   <= 5'h00;
						state_reg <= (len_clip == 8'h00) ? DIP_ST_CHECK : DIP_ST_DATA;
					end
				end
				DIP_ST_DATA: begin
					if (rx_valid) begin
						idx_reg <= idx_reg + 5'h01;
						if (idx_reg + 5'h01 == len_reg) begin
							state_reg <= DIP_ST_CHECK;
							idx_reg   <= 5'h00;
						end
					end
				end
				DIP_ST_CHECK: begin
					// one character read per step; read data arrives a cycle later
					// an unreadable stored length falls to the else side and ends the check
					if (idx_reg <= len_use) begin
						idx_reg <= idx_reg + 5'h01;
					end else begin
						state_reg <= DIP_ST_RUN;
					end
				end
				DIP_ST_RUN: begin
					state_reg <= DIP_ST_RUN;
				end
				default: begin
					state_reg <= DIP_ST_INIT;
				end
			endcase
		end
	end

	// on a normal boot the stored length is read back before checking
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chk_pend_reg <= 1'b0;
		end else begin
			chk_pend_reg <= (state_reg == DIP_ST_CHECK) && (idx_reg != 5'h00)
				&& (idx_reg <= len_use);
		end
	end

	// length of a normal boot comes from storage location zero
	// the read port points at location zero for the whole of initialization
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			len_mem_reg <= 5'h00;
		end else if (state_reg == DIP_ST_INIT) begin
			len_mem_reg <= (mem_rdata > 8'(DIP_MAX_LEN)) ? 5'(DIP_MAX_LEN) : mem_rdata[4:0];
		end
	end

	// range check over every stored character
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bad_reg <= 1'b0;
		end else if (state_reg == DIP_ST_INIT) begin
			bad_reg <= 1'b0;
		end else if (chk_pend_reg) begin
			if (mem_rdata < DIP_CHAR_MIN || mem_rdata > DIP_CHAR_MAX) begin
				bad_reg <= 1'b1;
			end
		end
	end

	// a normal boot checks the stored length rather than a freshly received one
	assign len_use = sel_prog_reg ? len_reg : len_mem_reg;

	//------------------------------------------------------------------
	// storage
	//------------------------------------------------------------------
	// length first, then characters at consecutive locations
	assign mem_wr    = rx_valid && ((state_reg == DIP_ST_LEN) || (state_reg == DIP_ST_DATA));
	assign mem_waddr = (state_reg == DIP_ST_LEN) ? DIP_LEN_ADDR : idx_reg + 5'h01;
	assign mem_raddr = (state_reg == DIP_ST_RUN) ? disc_addr
		: ((state_reg == DIP_ST_CHECK) ? idx_reg : DIP_LEN_ADDR);

	dip_id_mem u_mem (
		.ref_clk (ref_clk),
		.wr_en   (mem_wr),
		.wr_addr (mem_waddr),
		.wr_data ((state_reg == DIP_ST_LEN) ? len_clip : rx_data),
		.rd_addr (mem_raddr),
		.rd_data (mem_rdata)
	);

	//------------------------------------------------------------------
	// outputs
	//------------------------------------------------------------------
	// cts high holds the host off except while bytes are awaited
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cts_pin    <= 1'b1;
			prog_mode  <= 1'b0;
			init_done  <= 1'b0;
			link_allow <= 1'b0;
			disc_data  <= 8'h00;
		end else begin
			cts_pin    <= !((state_reg == DIP_ST_LEN) || (state_reg == DIP_ST_DATA));
			prog_mode  <= (state_reg == DIP_ST_LEN) || (state_reg == DIP_ST_DATA);
			init_done  <= (state_reg == DIP_ST_RUN);
			link_allow <= (state_reg == DIP_ST_RUN) && !bad_reg;
			disc_data  <= (state_reg == DIP_ST_RUN) ? mem_rdata : 8'h00;
		end
	end
endmodule

// ### rtl/dip_pkg.sv
// constants and types for the device id string programming block
//------------------------------------------------------------------
// Summary of operation
// - At reset exit the block enters id programming only when dtr is high and rts is low.
// - The dtr and rts levels are judged only until initialization ends; later changes do nothing.
// - In programming mode the block drives cts low once ready and uses cts to pace each byte.
// - The first byte is the string length; the following bytes are counted and programming ends.
// - A stored string with any character outside the permitted range blocks any link.
// - The stored string holds at most 19 characters.
//------------------------------------------------------------------
package dip_pkg;
	localparam int          DIP_MAX_LEN      = 19;
	localparam int          DIP_MEM_WORDS    = DIP_MAX_LEN + 1;
	localparam logic [7:0]  DIP_CHAR_MIN     = 8'h20;
	localparam logic [7:0]  DIP_CHAR_MAX     = 8'h7A;
	localparam logic [4:0]  DIP_LEN_ADDR     = 5'h00;
	// initialization time after reset release, in ns, and its cycle count
	localparam int          DIP_INIT_NS      = 1000;
	localparam int          DIP_CLK_NS       = 4;
	localparam int          DIP_INIT_CYC     = (DIP_INIT_NS + DIP_CLK_NS - 1) / DIP_CLK_NS;
	localparam logic [7:0]  DIP_INIT_LAST    = 8'(DIP_INIT_CYC - 1);

	typedef enum logic [4:0] {
		DIP_ST_INIT  = 5'b00001,
		DIP_ST_LEN   = 5'b00010,
		DIP_ST_DATA  = 5'b00100,
		DIP_ST_CHECK = 5'b01000,
		DIP_ST_RUN   = 5'b10000
	} dip_state_e;
endpackage

// ### rtl/dip_id_mem.sv
// storage array for the length byte and the identification string
`timescale 1ns/1ps
module dip_id_mem
	import dip_pkg::*;
(
	// clock
	input  wire logic       ref_clk,
	// write port
	input  wire logic       wr_en,
	input  wire logic [4:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// read port
	input  wire logic [4:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem_reg [DIP_MEM_WORDS];

	// no reset on the array: contents model nonvolatile storage
	always_ff @(posedge ref_clk) begin
		if (wr_en && (wr_addr < 5'(DIP_MEM_WORDS))) begin
			mem_reg[wr_addr] <= wr_data;
		end
		rd_data <= (rd_addr < 5'(DIP_MEM_WORDS)) ? mem_reg[rd_addr] : 8'h00;
	end
endmodule

// ### sim/dip_monitor.sv
// concurrent checks on the id programming block ports
`timescale 1ns/1ps
module dip_monitor
	import dip_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// watched outputs
	input wire logic cts_pin,
	input wire logic prog_mode,
	input wire logic init_done,
	input wire logic link_allow
);
	//------------------------------------------------------------------
	// properties
	//------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// cts is the byte pacing flag, so it must mirror the accepting state
	a_cts_paces_bytes: assert property (cts_pin == !prog_mode)
		else $error("cts level disagrees with programming state");
	a_init_quiet_start: assert property ($rose(rst_b) |-> (!prog_mode && !init_done)[*8])
		else $error("mode chosen before initialization ended");
	// two release edges, the timer, then up to 21 check steps for a full stored string
	a_init_ends_bound: assert property ($rose(rst_b) |-> ##[253:274] (prog_mode || init_done))
		else $error("initialization did not end in time");
	a_prog_not_run: assert property (prog_mode |-> !init_done)
		else $error("programming and normal run together");
	a_no_late_entry: assert property ($rose(prog_mode) |-> !$past(init_done))
		else $error("programming entered after initialization");
	a_prog_then_run: assert property ($fell(prog_mode) |-> ##[1:30] init_done)
		else $error("normal run not resumed after last byte");
	a_link_needs_run: assert property (link_allow |-> init_done)
		else $error("link allowed outside normal run");
	a_run_holds: assert property (init_done |=> init_done && $stable(link_allow))
		else $error("normal run or link permission changed");
	// main scenarios reached
	c_prog_entry: cover property ($rose(prog_mode));
	c_link_ok: cover property ($rose(link_allow));
	c_link_refused: cover property ($rose(init_done) ##1 !link_allow);
endmodule

// ### sim/dip_host_model.sv
// host controller model: mode pins and paced id string bytes
`timescale 1ns/1ps
module dip_host_model (
	// clock and pacing input
	input wire logic       ref_clk,
	input wire logic       cts_pin,
	// control from the bench
	input wire logic       go,
	input wire logic [7:0] len,
	input wire logic [7:0] base,
	input wire logic       dtr_req,
	input wire logic       rts_req,
	// lines toward the device, and done back to the bench
	output logic           dtr_pin,
	output logic           rts_pin,
	output logic           rx_valid = 1'b0,
	output logic     [7:0] rx_data = 8'h00,
	output logic           done = 1'b0
);
	logic [7:0] cnt = 8'h00;
	// dtr dropped after the last byte so a later reset boots normally
	assign dtr_pin = done ? 1'b0 : dtr_req;
	assign rts_pin = rts_req;
	// one byte per pulse, a gap after each so cts is looked at again
	always @(negedge ref_clk) begin
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data; // idle data inverts every cycle, so it differs from the byte just sent on the cycle after it
		if (!go) begin
			cnt  <= 8'h00;
			done <= 1'b0;
		end else if (!done && !rx_valid && !cts_pin) begin
			rx_valid <= 1'b1;
			rx_data  <= (cnt == 8'h00) ? len : 8'(base + cnt - 8'h01);
			cnt      <= cnt + 8'h01;
			done     <= (cnt == len);
		end
	end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the id string programming block
`timescale 1ns/1ps
module tb_top;
	import dip_pkg::*;
	logic ref_clk = 1'b0, rst_b = 1'b0, dtr_req = 1'b0, rts_req = 1'b1, go = 1'b0;
	logic [7:0] len = 8'h00, base = 8'h41;
	logic [4:0] disc_addr = 5'h00;
	logic dtr_pin, rts_pin, cts_pin, rx_valid, prog_mode, init_done, link_allow, done;
	logic [7:0] rx_data, disc_data;
	int err_count = 0, n_checks = 0;
	// rows: dtr, rts, expected programming state
	logic [2:0] rows [4] = '{3'b000, 3'b010, 3'b101, 3'b110};
	always #2 ref_clk = ~ref_clk;
	dip_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .dtr_pin(dtr_pin), .rts_pin(rts_pin),
		.cts_pin(cts_pin), .rx_valid(rx_valid), .rx_data(rx_data), .disc_addr(disc_addr),
		.disc_data(disc_data), .prog_mode(prog_mode), .init_done(init_done),
		.link_allow(link_allow));
	dip_host_model u_host (.ref_clk(ref_clk), .cts_pin(cts_pin), .go(go), .len(len),
		.base(base), .dtr_req(dtr_req), .rts_req(rts_req), .dtr_pin(dtr_pin),
		.rts_pin(rts_pin), .rx_valid(rx_valid), .rx_data(rx_data), .done(done));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// reset with chosen mode pins, then wait out initialization
	task automatic do_reset(input logic d, input logic r);
		rst_b = 1'b0;
		dtr_req = d;
		rts_req = r;
		repeat (6) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (270) @(negedge ref_clk);
	endtask
	// discovery read, answer two cycles after the address
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		disc_addr = a;
		repeat (3) @(negedge ref_clk);
		chk("disc_data", exp, disc_data);
	endtask
	task automatic prog(input logic [7:0] l, input logic [7:0] b, input logic ok);
		len = l;
		base = b;
		do_reset(1'b1, 1'b0);
		go = 1'b1;
		for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge ref_clk);
		repeat (40) @(negedge ref_clk);
		chk("init_done", 8'h01, 8'(init_done));
		chk("cts_pin", 8'h01, 8'(cts_pin));
		chk("link_allow", 8'(ok), 8'(link_allow));
		rd(5'h00, l);
		for (int k = 1; k <= l; k++) rd(5'(k), 8'(b + k - 1));
		go = 1'b0;
	endtask
	// hang guard, sized well past the whole sequence
	initial begin
		#100000;
		err_count++;
		stop_test();
	end
	// main sequence
	initial begin
		foreach (rows[i]) begin
			do_reset(rows[i][2], rows[i][1]);
			chk("prog_mode", 8'(rows[i][0]), 8'(prog_mode));
			chk("cts_pin", 8'(!rows[i][0]), 8'(cts_pin));
			if (!rows[i][0]) begin
				dtr_req = 1'b1;
				rts_req = 1'b0;
				repeat (8) @(negedge ref_clk);
				chk("late prog_mode", 8'h00, 8'(prog_mode));
			end
		end
		prog(8'd2, 8'h7A, 1'b0);
		// a normal boot must check the stored string, not only a fresh one
		do_reset(1'b0, 1'b1);
		chk("bad stored link_allow", 8'h00, 8'(link_allow));
		chk("bad stored init_done", 8'h01, 8'(init_done));
		prog(8'd19, 8'h41, 1'b1);
		prog(8'd3, 8'h41, 1'b1);
		do_reset(1'b0, 1'b1);
		chk("stored link_allow", 8'h01, 8'(link_allow));
		rd(5'h00, 8'd3);
		stop_test();
	end
endmodule
bind dip_top dip_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .cts_pin(cts_pin),
	.prog_mode(prog_mode), .init_done(init_done), .link_allow(link_allow));
